// ===== bench/test_wec_wakeup_counter.sv
// testbench: register-level checks of the wake-up event counter
module test_wec_wakeup_counter
  import wec_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [1:0] bresp, rresp, resp;
  logic [PIN_W-1:0] pressed = '0;
  wec_pins_s gpio_in;
  int num_errors = 0;
  int comparisons = 0;
  int lsb[4] = '{0, 8, 14, 24};
  int wid[4] = '{8, 6, 10, 8};
  always #2.5 aclk = ~aclk;

  wec_keys wec_keys_i (.pressed(pressed), .gpio_in(gpio_in));
  // MS_CNT of 4 keeps a millisecond of debounce to a few cycles
  wec_wakeup_counter #(.AW(12), .MS_CNT(4)) wec_wakeup_counter_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .gpio_in(gpio_in), .irq(irq));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    awaddr <= {2'h0, idx, 2'h0};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        done = 1'b1;
        resp = bresp;
        bready <= 1'b0;
      end
    end
  endtask

  task automatic rdr(input logic [7:0] idx);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    araddr <= {2'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        done = 1'b1;
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
      end
    end
  endtask

  task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
    rdr(idx);
    chk($sformatf("reg %h", idx), rd, exp);
  endtask

  // the count shows three edges after the pin moves, so four are allowed
  task automatic key(input int b, input logic v, input int hold);
    @(posedge aclk);
    pressed[b] <= v;
    repeat (hold) @(posedge aclk);
  endtask

  initial begin
    repeat (5000) @(posedge aclk);
    num_errors++;
    give_verdict();
  end

  initial begin
    int b;
    logic [31:0] m;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(IDX_COUNT, 32'h0);
    for (int p = 0; p < 4; p++) begin
      rchk(8'(IDX_EN0 + 2 * p), 32'h0);
      rchk(8'(IDX_POL0 + 2 * p), 32'h0);
    end
    // top input of each port: falling, then rising, then disabled
    for (int p = 0; p < 4; p++) begin
      b = lsb[p] + wid[p] - 1;
      m = 32'h1 << (wid[p] - 1);
      wr(8'(IDX_POL0 + 2 * p), m);
      wr(8'(IDX_EN0 + 2 * p), m);
      key(b, 1'b1, 4);
      rchk(IDX_COUNT, 32'(2 * p + 1));
      // polarity flipped while held low, so no edge comes from the write
      wr(8'(IDX_POL0 + 2 * p), 32'h0);
      key(b, 1'b0, 4);
      rchk(IDX_COUNT, 32'(2 * p + 2));
      wr(8'(IDX_EN0 + 2 * p), 32'h0);
      key(b, 1'b1, 4);
      key(b, 1'b0, 4);
      rchk(IDX_COUNT, 32'(2 * p + 2));
    end
    wr(IDX_CNT_CLR, 32'hffff);
    rchk(IDX_COUNT, 32'h0);
    wr(IDX_COMPARE, 32'h2);
    wr(IDX_IRQ_MASK, 32'h1);
    wr(IDX_CTRL, 32'h80);
    wr(IDX_POL0, 32'h1);
    wr(IDX_EN0, 32'h1);
    key(0, 1'b1, 4);
    key(0, 1'b0, 4);
    chk("irq", 32'(irq), 32'h0);
    key(0, 1'b1, 4);
    key(0, 1'b0, 4);
    chk("irq", 32'(irq), 32'h1);
    wr(IDX_IRQ_CLR, 32'h0);
    chk("irq", 32'(irq), 32'h0);
    rchk(IDX_COUNT, 32'h0);
    rchk(IDX_IRQ_CLR, 32'h0);
    wr(IDX_CTRL, 32'hc0);
    rchk(IDX_COUNT, 32'h1);
    wr(IDX_CTRL, 32'hc0);
    rchk(IDX_COUNT, 32'h1);
    wr(IDX_CTRL, 32'h80);
    wr(IDX_CTRL, 32'hc0);
    rchk(IDX_COUNT, 32'h2);
    chk("irq", 32'(irq), 32'h1);
    wr(IDX_IRQ_STATUS, 32'h1);
    chk("irq", 32'(irq), 32'h0);
    rchk(IDX_COUNT, 32'h0);
    // one millisecond of debounce: a short glitch is dropped
    wr(IDX_CTRL, 32'h01);
    wr(IDX_CNT_CLR, 32'h0);
    key(0, 1'b1, 2);
    key(0, 1'b0, 12);
    rchk(IDX_COUNT, 32'h0);
    key(0, 1'b1, 12);
    rchk(IDX_COUNT, 32'h1);
    key(0, 1'b0, 12);
    rdr(8'h30);
    chk("rresp", 32'(resp), 32'(RESP_SLVERR));
    wr(8'h30, 32'h1);
    chk("bresp", 32'(resp), 32'(RESP_SLVERR));
    give_verdict();
  end
endmodule

// ===== bench/wec_keys.sv
// partner model: keys with pull-ups on the wake-up inputs
module wec_keys
  import wec_pkg::*;
(
  // key state from the bench
  input wire logic [PIN_W-1:0] pressed,
  // pins
  output wec_pins_s gpio_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // open keys leave the pin on its pull-up, a closed key pulls it low
  assign gpio_in = wec_pins_s'(~pressed);
endmodule

// ===== rtl/wec_debounce.sv
// module: millisecond debounce filter for the combined key level
module wec_debounce
  import wec_pkg::*;
#(
  parameter int unsigned MS_CNT = MS_CYCLES
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // filter
  input wire logic raw_level,
  input wire logic [DEB_W-1:0] debounce_ms,
  output logic clean_level
);

  localparam int unsigned PRE_W = $clog2(MS_CNT + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(MS_CNT - 1);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [PRE_W-1:0] pre;
    logic [DEB_W-1:0] ms;
    logic lvl;
  } wec_deb_s;

  wec_deb_s s;
  wec_deb_s next_s;

  // any glitch restarts the wait, so a bouncing key never gets through
  always_comb begin
    next_s = s;
    if (debounce_ms == '0 || raw_level == s.lvl) begin
      next_s.pre = '0; // [R15]
      next_s.ms = '0;
      if (debounce_ms == '0) begin
        next_s.lvl = raw_level; // [R15]
      end
    end else if (s.pre == PRE_LAST) begin
      next_s.pre = '0;
      if (s.ms == debounce_ms - 1'b1) begin
        next_s.lvl = raw_level; // [R15]
        next_s.ms = '0;
      end else begin
        next_s.ms = s.ms + 1'b1;
      end
    end else begin
      next_s.pre = s.pre + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign clean_level = s.lvl;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_deb_full_wait: assert property (@(posedge aclk) disable iff (!aresetn) // [R15]
    $past(debounce_ms) != '0 && $changed(s.lvl)
      |-> $past(s.pre) == PRE_LAST && $past(s.ms) == $past(debounce_ms) - 1'b1)
    else $error("debounced level changed before the full stable time");

  a_deb_bypass: assert property (@(posedge aclk) disable iff (!aresetn) // [R15]
    $past(debounce_ms) == '0 |-> s.lvl == $past(raw_level))
    else $error("zero debounce did not pass the level through");

endmodule

// ===== rtl/wec_pkg.sv
// package: constants and carriers for the wake-up event counter
package wec_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned DEB_UNIT_NS = 1000000;
  localparam int unsigned MS_CYCLES = (DEB_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // register map: index = offset - base, byte address = 4 * index
  // ---------------------------------------------------------------
  localparam logic [31:0] BLOCK_BASE = 32'h5000_0100;
  localparam logic [31:0] OFS_CTRL = 32'h5000_0100;
  localparam logic [31:0] OFS_COMPARE = 32'h5000_0102;
  localparam logic [31:0] OFS_IRQ_CLR = 32'h5000_0104;
  localparam logic [31:0] OFS_COUNT = 32'h5000_0106;
  localparam logic [31:0] OFS_CNT_CLR = 32'h5000_0108;
  localparam logic [31:0] OFS_EN0 = 32'h5000_010a;
  localparam logic [31:0] OFS_EN1 = 32'h5000_010c;
  localparam logic [31:0] OFS_EN2 = 32'h5000_010e;
  localparam logic [31:0] OFS_EN3 = 32'h5000_0110;
  localparam logic [31:0] OFS_POL0 = 32'h5000_0112;
  localparam logic [31:0] OFS_POL1 = 32'h5000_0114;
  localparam logic [31:0] OFS_POL2 = 32'h5000_0116;
  localparam logic [31:0] OFS_POL3 = 32'h5000_0118;
  localparam logic [31:0] OFS_IRQ_STATUS = 32'h5000_0120;
  localparam logic [31:0] OFS_IRQ_MASK = 32'h5000_0122;

  localparam logic [7:0] IDX_CTRL = 8'(OFS_CTRL - BLOCK_BASE);
  localparam logic [7:0] IDX_COMPARE = 8'(OFS_COMPARE - BLOCK_BASE);
  localparam logic [7:0] IDX_IRQ_CLR = 8'(OFS_IRQ_CLR - BLOCK_BASE);
  localparam logic [7:0] IDX_COUNT = 8'(OFS_COUNT - BLOCK_BASE);
  localparam logic [7:0] IDX_CNT_CLR = 8'(OFS_CNT_CLR - BLOCK_BASE);
  localparam logic [7:0] IDX_EN0 = 8'(OFS_EN0 - BLOCK_BASE);
  localparam logic [7:0] IDX_EN1 = 8'(OFS_EN1 - BLOCK_BASE);
  localparam logic [7:0] IDX_EN2 = 8'(OFS_EN2 - BLOCK_BASE);
  localparam logic [7:0] IDX_EN3 = 8'(OFS_EN3 - BLOCK_BASE);
  localparam logic [7:0] IDX_POL0 = 8'(OFS_POL0 - BLOCK_BASE);
  localparam logic [7:0] IDX_POL1 = 8'(OFS_POL1 - BLOCK_BASE);
  localparam logic [7:0] IDX_POL2 = 8'(OFS_POL2 - BLOCK_BASE);
  localparam logic [7:0] IDX_POL3 = 8'(OFS_POL3 - BLOCK_BASE);
  localparam logic [7:0] IDX_IRQ_STATUS = 8'(OFS_IRQ_STATUS - BLOCK_BASE);
  localparam logic [7:0] IDX_IRQ_MASK = 8'(OFS_IRQ_MASK - BLOCK_BASE);

  // ---------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------
  localparam int unsigned REG_W = 16;
  localparam logic [REG_W-1:0] REG_RESET = 16'h0000;
  localparam int unsigned CTRL_IRQ_EN_BIT = 7;
  localparam int unsigned CTRL_SOFT_KEY_BIT = 6;
  localparam int unsigned CTRL_DEB_LSB = 0;
  localparam int unsigned DEB_W = 6;
  localparam int unsigned CNT_W = 8;
  localparam int unsigned IRQ_W = 2;
  localparam int unsigned IRQ_WAKE_BIT = 0;
  localparam int unsigned IRQ_EVENT_BIT = 1;
  localparam int unsigned P0_W = 8;
  localparam int unsigned P1_W = 6;
  localparam int unsigned P2_W = 10;
  localparam int unsigned P3_W = 8;
  localparam int unsigned PIN_W = P0_W + P1_W + P2_W + P3_W;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [P3_W-1:0] p3;
    logic [P2_W-1:0] p2;
    logic [P1_W-1:0] p1;
    logic [P0_W-1:0] p0;
  } wec_pins_s;

endpackage

// ===== rtl/wec_sync.sv
// module: two-flop synchroniser for the wake-up inputs
module wec_sync
  import wec_pkg::*;
#(
  parameter int unsigned W = PIN_W
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] held;
  } wec_sync_s;

  wec_sync_s s;
  wec_sync_s next_s;

  // first stage feeds only the second stage
  always_comb begin
    next_s.meta = async_in;
    next_s.held = s.meta;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sync_out = s.held;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_sync_two_stage: assert property (@(posedge aclk) disable iff (!aresetn) // [R18]
    $past(aresetn) && $past(aresetn, 2) |-> sync_out == $past(async_in, 2))
    else $error("synchroniser output is not input delayed by two clocks");

endmodule

// ===== rtl/wec_wakeup_counter.sv
// module: wake-up event counter with axi4-lite registers
// ---------------------------------------------------------------
// Overview of operation
// [R1] count register low byte shows counted wake-up events, read only
// [R2] count register bits 15:8 always read as zero
// [R3] clearing the wake interrupt also zeroes the event counter
// [R4] any write to the count-clear register zeroes the counter
// [R5] port 0 inputs count only while their enable bit is one
// [R6] port 1 inputs count only while their enable bit is one
// [R7] port 2 inputs count only while their enable bit is one
// [R8] port 3 inputs count only while their enable bit is one
// [R9] port 0 polarity zero counts rising, one counts falling
// [R10] port 1 polarity zero counts rising, one counts falling
// [R11] port 2 polarity zero counts rising, one counts falling
// [R12] port 3 polarity zero counts rising, one counts falling
// [R13] enables, polarities and counter are zero after reset
// [R14] with interrupt enabled, reaching the compare value raises the interrupt
// [R15] debounce zero bypasses; 1 to 63 needs that many stable milliseconds
// [R16] soft key bit rising adds one event; software must drop it first
// [R17] any write to interrupt-clear clears the wake interrupt status bit; reads return zero
// [R18] inputs synchronised before edge detection; one event per clock
// ---------------------------------------------------------------
module wec_wakeup_counter
  import wec_pkg::*;
#(
  parameter int unsigned AW = 12,
  parameter int unsigned MS_CNT = MS_CYCLES
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  // axi4-lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // wake-up inputs
  input wire wec_pins_s gpio_in,
  // interrupt
  output logic irq
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic aw_full;
    logic [7:0] aw_idx;
    logic aw_hi;
    logic w_full;
    logic [REG_W-1:0] w_data;
    logic [1:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [REG_W-1:0] rdata;
    logic [1:0] rresp;
    logic irq_en;
    logic soft_key;
    logic [DEB_W-1:0] deb;
    logic [CNT_W-1:0] compare;
    logic [CNT_W-1:0] count;
    wec_pins_s en;
    wec_pins_s pol;
    logic [IRQ_W-1:0] status;
    logic [IRQ_W-1:0] mask;
    logic [PIN_W:0] act_q;
    logic deb_q;
  } wec_top_s;

  wec_top_s s;
  wec_top_s next_s;

  wec_pins_s pins_sync;
  logic [PIN_W:0] act;
  logic deb_lvl;
  logic evt;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic do_wr;
  logic wr_ok;
  logic wr_cnt_clr;
  logic wr_irq_clr;
  logic wr_status;
  logic wake_clr;
  logic clr_cnt;
  logic hit;
  logic [7:0] ar_idx;
  logic ar_hi;
  logic [REG_W-1:0] wr_merged;
  logic [IRQ_W-1:0] w1c;
  logic [CNT_W-1:0] count_base;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic mapped(input logic [7:0] idx);
    case (idx)
      IDX_CTRL, IDX_COMPARE, IDX_IRQ_CLR, IDX_COUNT, IDX_CNT_CLR,
      IDX_EN0, IDX_EN1, IDX_EN2, IDX_EN3, IDX_POL0, IDX_POL1, IDX_POL2, IDX_POL3,
      IDX_IRQ_STATUS, IDX_IRQ_MASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  // write-only registers and reserved bits read as zero
  function automatic logic [REG_W-1:0] rd_value(input logic [7:0] idx, input wec_top_s st);
    rd_value = REG_RESET;
    case (idx)
      IDX_CTRL: begin
        rd_value[CTRL_IRQ_EN_BIT] = st.irq_en;
        rd_value[CTRL_SOFT_KEY_BIT] = st.soft_key;
        rd_value[CTRL_DEB_LSB +: DEB_W] = st.deb;
      end
      IDX_COMPARE: rd_value[CNT_W-1:0] = st.compare;
      IDX_COUNT: rd_value[CNT_W-1:0] = st.count; // [R1] [R2]
      IDX_EN0: rd_value[P0_W-1:0] = st.en.p0;
      IDX_EN1: rd_value[P1_W-1:0] = st.en.p1;
      IDX_EN2: rd_value[P2_W-1:0] = st.en.p2;
      IDX_EN3: rd_value[P3_W-1:0] = st.en.p3;
      IDX_POL0: rd_value[P0_W-1:0] = st.pol.p0;
      IDX_POL1: rd_value[P1_W-1:0] = st.pol.p1;
      IDX_POL2: rd_value[P2_W-1:0] = st.pol.p2;
      IDX_POL3: rd_value[P3_W-1:0] = st.pol.p3;
      IDX_IRQ_STATUS: rd_value[IRQ_W-1:0] = st.status;
      IDX_IRQ_MASK: rd_value[IRQ_W-1:0] = st.mask;
      default: rd_value = REG_RESET; // [R17]
    endcase
  endfunction

  function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] old_v,
                                             input logic [REG_W-1:0] new_v,
                                             input logic [1:0] strb);
    merge = old_v;
    if (strb[0]) begin
      merge[7:0] = new_v[7:0];
    end
    if (strb[1]) begin
      merge[15:8] = new_v[15:8];
    end
  endfunction

  // ---------------------------------------------------------------
  // input path
  // ---------------------------------------------------------------
  wec_sync #(
    .W(PIN_W)
  ) wec_sync_i (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(gpio_in),
    .sync_out(pins_sync) // [R18]
  );

  // soft key rides as an extra input so it shares the debounce path
  assign act = {s.soft_key, s.en & (pins_sync ^ s.pol)}; // [R5] [R6] [R7] [R8] [R9] [R10] [R11] [R12] [R16]

  wec_debounce #(
    .MS_CNT(MS_CNT)
  ) wec_debounce_i (
    .aclk(aclk),
    .aresetn(aresetn),
    .raw_level(|act),
    .debounce_ms(s.deb),
    .clean_level(deb_lvl)
  );

  // coincident edges on several inputs collapse into one count
  assign evt = (s.deb == '0) ? |(act & ~s.act_q) : (deb_lvl & ~s.deb_q); // [R18] [R15]

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  assign s_axi_awready = !s.aw_full;
  assign s_axi_wready = !s.w_full;
  assign s_axi_arready = !s.rvalid;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign ar_idx = s_axi_araddr[9:2];
  assign ar_hi = |s_axi_araddr[AW-1:10];
  assign do_wr = s.aw_full && s.w_full && !s.bvalid;
  assign wr_ok = do_wr && !s.aw_hi && mapped(s.aw_idx);
  assign wr_cnt_clr = wr_ok && s.aw_idx == IDX_CNT_CLR; // [R4]
  assign wr_irq_clr = wr_ok && s.aw_idx == IDX_IRQ_CLR; // [R17]
  assign wr_status = wr_ok && s.aw_idx == IDX_IRQ_STATUS;
  assign w1c = s.w_data[IRQ_W-1:0] & {IRQ_W{s.w_strb[0]}};
  assign wake_clr = wr_irq_clr || (wr_status && w1c[IRQ_WAKE_BIT]);
  assign clr_cnt = wr_cnt_clr || wake_clr; // [R3] [R4]
  assign wr_merged = merge(rd_value(s.aw_idx, s), s.w_data, s.w_strb);
  // an event in the clearing cycle survives as a count of one
  assign count_base = clr_cnt ? '0 : s.count;
  assign hit = evt && s.irq_en && (count_base + 1'b1 == s.compare); // [R14]

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    if (aw_take) begin
      next_s.aw_full = 1'b1;
      next_s.aw_idx = s_axi_awaddr[9:2];
      next_s.aw_hi = |s_axi_awaddr[AW-1:10];
    end
    if (w_take) begin
      next_s.w_full = 1'b1;
      next_s.w_data = s_axi_wdata[REG_W-1:0];
      next_s.w_strb = s_axi_wstrb[1:0];
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (do_wr) begin
      next_s.aw_full = 1'b0;
      next_s.w_full = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (wr_ok) begin
      case (s.aw_idx)
        IDX_CTRL: begin
          next_s.irq_en = wr_merged[CTRL_IRQ_EN_BIT];
          next_s.soft_key = wr_merged[CTRL_SOFT_KEY_BIT];
          next_s.deb = wr_merged[CTRL_DEB_LSB +: DEB_W];
        end
        IDX_COMPARE: next_s.compare = wr_merged[CNT_W-1:0];
        IDX_EN0: next_s.en.p0 = wr_merged[P0_W-1:0]; // [R5]
        IDX_EN1: next_s.en.p1 = wr_merged[P1_W-1:0]; // [R6]
        IDX_EN2: next_s.en.p2 = wr_merged[P2_W-1:0]; // [R7]
        IDX_EN3: next_s.en.p3 = wr_merged[P3_W-1:0]; // [R8]
        IDX_POL0: next_s.pol.p0 = wr_merged[P0_W-1:0]; // [R9]
        IDX_POL1: next_s.pol.p1 = wr_merged[P1_W-1:0]; // [R10]
        IDX_POL2: next_s.pol.p2 = wr_merged[P2_W-1:0]; // [R11]
        IDX_POL3: next_s.pol.p3 = wr_merged[P3_W-1:0]; // [R12]
        IDX_IRQ_MASK: next_s.mask = wr_merged[IRQ_W-1:0];
        default: ;
      endcase
    end
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (ar_take) begin
      next_s.rvalid = 1'b1;
      next_s.rdata = (!ar_hi && mapped(ar_idx)) ? rd_value(ar_idx, s) : REG_RESET;
      next_s.rresp = (!ar_hi && mapped(ar_idx)) ? RESP_OKAY : RESP_SLVERR;
    end
    next_s.count = count_base + CNT_W'(evt); // [R1] [R3] [R4]
    next_s.status = s.status & ~(wr_status ? w1c : '0);
    if (wake_clr) begin
      next_s.status[IRQ_WAKE_BIT] = 1'b0; // [R17]
    end
    // set wins over a clear in the same cycle
    next_s.status[IRQ_WAKE_BIT] = next_s.status[IRQ_WAKE_BIT] | hit; // [R14]
    next_s.status[IRQ_EVENT_BIT] = next_s.status[IRQ_EVENT_BIT] | evt;
    next_s.act_q = act;
    next_s.deb_q = deb_lvl;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0; // [R13]
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = {16'h0000, s.rdata};
  assign s_axi_rresp = s.rresp;
  assign irq = |(s.status & s.mask);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_count_read: assert property ( // [R1] [R2]
    ar_take && !ar_hi && ar_idx == IDX_COUNT
      |=> s_axi_rdata == {24'h000000, $past(s.count)} && s_axi_rresp == RESP_OKAY)
    else $error("count read did not return the counter in the low byte");

  a_irq_clr_reads_zero: assert property ( // [R17]
    ar_take && !ar_hi && ar_idx == IDX_IRQ_CLR |=> s_axi_rvalid && s_axi_rdata == 32'h00000000)
    else $error("interrupt clear register read was not zero");

  a_wake_clear_count: assert property ( // [R3]
    wr_irq_clr && !evt |=> s.count == '0 && !s.status[IRQ_WAKE_BIT])
    else $error("interrupt clear left the counter or interrupt set");

  a_count_clear: assert property ( // [R4]
    wr_cnt_clr && !evt |=> s.count == '0)
    else $error("count clear write did not zero the counter");

  a_input_gated: assert property ( // [R5] [R6] [R7] [R8]
    (s.en == '0 && !s.soft_key) [*2] |-> !evt || s.deb != '0)
    else $error("an event was counted with every input disabled");

  a_edge_counts: assert property ( // [R9] [R10] [R11] [R12] [R18]
    s.deb == '0 && |(act & ~s.act_q) && !clr_cnt |=> s.count == $past(s.count) + 1'b1)
    else $error("a qualifying edge did not add exactly one event");

  a_falling_counts: assert property ( // [R9]
    s.deb == '0 && s.en.p0[0] && s.pol.p0[0] && $fell(pins_sync.p0[0])
      && $stable(s.en) && $stable(s.pol) && !clr_cnt |=> s.count == $past(s.count) + 1'b1)
    else $error("falling edge with polarity one was not counted");

  a_reset_zero: assert property ( // [R13]
    $past(!aresetn) |-> s.count == '0 && s.en == '0 && s.pol == '0 && !irq)
    else $error("state not zero after reset");

  a_wake_raise: assert property ( // [R14]
    hit ##1 s.mask[IRQ_WAKE_BIT] |-> s.status[IRQ_WAKE_BIT] && irq)
    else $error("compare reached with interrupt enabled but no interrupt");

  a_soft_hit: assert property ( // [R16]
    s.deb == '0 && $rose(s.soft_key) && !clr_cnt |=> s.count == $past(s.count) + 1'b1)
    else $error("soft key press did not add one event");

  c_wake_hit: cover property (hit);
  c_debounced_event: cover property (evt && s.deb != '0);
  c_unmapped_read: cover property (ar_take && !mapped(ar_idx));
  c_soft_event: cover property ($rose(s.soft_key) ##[1:4] evt);

endmodule
